// ### hdl/cesr_regs.vh
// Purpose: Constants for the error and status reporting block
// Assumes: 16-bit registers on a plain strobe port
// Notes:   Offsets are byte addresses
`ifndef CESR_REGS_VH
`define CESR_REGS_VH
`define CESR_ADDR_W        8
`define CESR_OFF_STATUS    8'h04
`define CESR_OFF_ERRCNT    8'h08
`define CESR_OFF_CTRL      8'h00
`define CESR_OFF_INTID     8'h10
`define CESR_LEC_NONE      3'h0
`define CESR_LEC_STUFF     3'h1
`define CESR_LEC_FORM      3'h2
`define CESR_LEC_ACK       3'h3
`define CESR_LEC_BIT1      3'h4
`define CESR_LEC_BIT0      3'h5
`define CESR_LEC_CRC       3'h6
`define CESR_LEC_UNUSED    3'h7
`define CESR_WARN_LIMIT    8'h60
`define CESR_PASSIVE_LIMIT 8'h80
`define CESR_INT_STATUS    16'h8000
`define CESR_ERRCNT_RESET  16'h0000
`define CESR_STAT_LEC_HI   2
`define CESR_STAT_TX_SUCCESS_FLAG     3
`define CESR_STAT_RX_SUCCESS_FLAG     4
`define CESR_STAT_ERROR_PASSIVE_FLAG    5
`define CESR_STAT_WARNING_LIMIT_FLAG    6
`define CESR_STAT_BUS_OFF_FLAG     7
`define CESR_CTRL_SIE      2
`define CESR_CTRL_EIE      3
`endif

// ### hdl/cesr_error_status.v
// Purpose: Last error code, status flags, status interrupt and error
//          counter register of a CAN controller
// Assumes: Protocol engine supplies one-cycle event pulses and live counts
// Notes:   One clock domain; engine inputs are on sys_clk
//
// Behaviour
// - Stuff error stores code 1
// - Form error stores code 2
// - Unacknowledged transmission stores code 3
// - Sent recessive, saw dominant outside arbitration stores code 4
// - Sent dominant, saw recessive stores code 5
// - Each eleven recessive bits during bus-off recovery stores code 5
// - CRC mismatch stores code 6
// - Software may write 7; kept until a bus event overwrites it
// - Error-free reception or transmission clears the code to 0
// - Bus-off or warning change raises status interrupt when enabled
// - Success flag or code update by hardware raises it when enabled
// - Passive change or software writes never raise the interrupt
// - Reading status clears the pending status interrupt identifier
// - Bit 15 shows receive count at error-passive level
// - Bits 14:8 show live receive error count
// - Bits 7:0 show live transmit error count
// - Error counter register is read-only at 0x08, resets to zero
// - Warning flag when either counter reaches 96
// - Success flags set by hardware, cleared only by software
// - Bus-off flag follows bus-off state
`timescale 1ns/1ps
`default_nettype none
`include "cesr_regs.vh"
module cesr_error_status (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire [7:0]  regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWrStb,
   input  wire        regRdStb,
   output reg  [15:0] regRdData,
   input  wire        stuffErr,
   input  wire        formErr,
   input  wire        missingAckErr,
   input  wire        recessiveMismatchErr,
   input  wire        dominantMismatchErr,
   input  wire        recoveryElevenRecessive,
   input  wire        checksumMismatchErr,
   input  wire        rxDone,
   input  wire        txDone,
   input  wire        busOffState,
   input  wire        errorPassiveState,
   input  wire [7:0]  receiveErrorCount,
   input  wire [7:0]  transmitErrorCount,
   output wire        statusIrq
);

   reg  [2:0]  lastErrorCode_reg;
   reg  [2:0]  lastErrorCode_next;
   reg         rxSuccessFlag_reg;
   reg         txSuccessFlag_reg;
   reg         busOffFlag_reg;
   reg         warningLimitFlag_reg;
   reg         errorPassiveFlag_reg;
   reg         errIntEn_reg;
   reg         statIntEn_reg;
   reg         intPending_reg;
   reg         hwLecUpdate;
   wire        warnNext;
   wire        wrStatus;
   wire        wrCtrl;
   wire        rdStatus;
   wire        errRaise;
   wire        statRaise;
   wire [15:0] statusWord;
   wire [15:0] errCntWord;

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   assign wrStatus = regWrStb & hit(regAddr, `CESR_OFF_STATUS);
   assign wrCtrl   = regWrStb & hit(regAddr, `CESR_OFF_CTRL);
   assign rdStatus = regRdStb & hit(regAddr, `CESR_OFF_STATUS);

   // ------------------------------------------------------------
   // Last error code
   // ------------------------------------------------------------
   // Later lines win, so a same-cycle bus event beats a software write
   always @* begin
      lastErrorCode_next = lastErrorCode_reg;
      hwLecUpdate = 1'b0;
      if (wrStatus) begin
         lastErrorCode_next = regWrData[`CESR_STAT_LEC_HI:0];
      end
      if (rxDone | txDone) begin
         lastErrorCode_next = `CESR_LEC_NONE;
         hwLecUpdate = 1'b1;
      end
      if (stuffErr) begin
         lastErrorCode_next = `CESR_LEC_STUFF;
         hwLecUpdate = 1'b1;
      end else if (formErr) begin
         lastErrorCode_next = `CESR_LEC_FORM;
         hwLecUpdate = 1'b1;
      end else if (missingAckErr) begin
         lastErrorCode_next = `CESR_LEC_ACK;
         hwLecUpdate = 1'b1;
      end else if (recessiveMismatchErr) begin
         lastErrorCode_next = `CESR_LEC_BIT1;
         hwLecUpdate = 1'b1;
      end else if (dominantMismatchErr | recoveryElevenRecessive) begin
         lastErrorCode_next = `CESR_LEC_BIT0;
         hwLecUpdate = 1'b1;
      end else if (checksumMismatchErr) begin
         lastErrorCode_next = `CESR_LEC_CRC;
         hwLecUpdate = 1'b1;
      end
   end

   assign warnNext = (receiveErrorCount >= `CESR_WARN_LIMIT) |
                     (transmitErrorCount >= `CESR_WARN_LIMIT);

   // Passive changes feed neither term
   assign errRaise  = errIntEn_reg &
                      ((busOffFlag_reg ^ busOffState) |
                       (warningLimitFlag_reg ^ warnNext));
   assign statRaise = statIntEn_reg &
                      (hwLecUpdate | rxDone | txDone);

   // ------------------------------------------------------------
   // Flags and interrupt
   // ------------------------------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lastErrorCode_reg    <= `CESR_LEC_NONE;
         rxSuccessFlag_reg    <= 1'b0;
         txSuccessFlag_reg    <= 1'b0;
         busOffFlag_reg       <= 1'b0;
         warningLimitFlag_reg <= 1'b0;
         errorPassiveFlag_reg <= 1'b0;
         errIntEn_reg         <= 1'b0;
         statIntEn_reg        <= 1'b0;
         intPending_reg       <= 1'b0;
      end else begin
         lastErrorCode_reg    <= lastErrorCode_next;
         busOffFlag_reg       <= busOffState;
         warningLimitFlag_reg <= warnNext;
         errorPassiveFlag_reg <= errorPassiveState;
         // Set wins over a software clear in the same cycle
         if (rxDone) begin
            rxSuccessFlag_reg <= 1'b1;
         end else if (wrStatus) begin
            rxSuccessFlag_reg <= regWrData[`CESR_STAT_RX_SUCCESS_FLAG];
         end
         if (txDone) begin
            txSuccessFlag_reg <= 1'b1;
         end else if (wrStatus) begin
            txSuccessFlag_reg <= regWrData[`CESR_STAT_TX_SUCCESS_FLAG];
         end
         if (wrCtrl) begin
            errIntEn_reg  <= regWrData[`CESR_CTRL_EIE];
            statIntEn_reg <= regWrData[`CESR_CTRL_SIE];
         end
         if (errRaise | statRaise) begin
            intPending_reg <= 1'b1;
         end else if (rdStatus) begin
            intPending_reg <= 1'b0;
         end
      end
   end

   assign statusIrq = intPending_reg;

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   assign statusWord = {8'h00, busOffFlag_reg, warningLimitFlag_reg,
                        errorPassiveFlag_reg, rxSuccessFlag_reg,
                        txSuccessFlag_reg, lastErrorCode_reg};
   assign errCntWord = {(receiveErrorCount >= `CESR_PASSIVE_LIMIT),
                        receiveErrorCount[6:0],
                        transmitErrorCount};

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdData <= `CESR_ERRCNT_RESET;
      end else if (regRdStb) begin
         if (hit(regAddr, `CESR_OFF_ERRCNT)) begin
            regRdData <= errCntWord;
         end else if (hit(regAddr, `CESR_OFF_STATUS)) begin
            regRdData <= statusWord;
         end else if (hit(regAddr, `CESR_OFF_CTRL)) begin
            regRdData <= {12'h000, errIntEn_reg, statIntEn_reg, 2'h0};
         end else if (hit(regAddr, `CESR_OFF_INTID)) begin
            regRdData <= intPending_reg ? `CESR_INT_STATUS : 16'h0000;
         end else begin
            regRdData <= 16'h0000;
         end
      end else begin
         regRdData <= 16'h0000;
      end
   end

endmodule // cesr_error_status
`default_nettype wire

// ### dv/cesr_monitor.sv
// Purpose: Port assertions for the error status block
// Assumes: Engine events are one-cycle pulses
// Notes:   Code checks fire on a status read right after a lone event
`timescale 1ns/1ps
`default_nettype none
module cesr_monitor (
   input wire        sys_clk, rst, regWrStb, regRdStb, statusIrq,
   input wire [7:0]  regAddr, receiveErrorCount, transmitErrorCount,
   input wire [15:0] regWrData, regRdData,
   input wire        stuffErr, formErr, missingAckErr, recessiveMismatchErr,
   input wire        dominantMismatchErr, recoveryElevenRecessive,
   input wire        checksumMismatchErr, rxDone, txDone, busOffState,
   input wire        errorPassiveState
);
   wire [8:0] ev = {stuffErr, formErr, missingAckErr, recessiveMismatchErr,
      dominantMismatchErr, recoveryElevenRecessive, checksumMismatchErr,
      rxDone, txDone};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_rd(a); regRdStb && regAddr == a; endsequence
   sequence s_srd; regRdStb && regAddr == 8'h04 && ev == 9'h000; endsequence
   sequence s_ev(e); e && $countones(ev) == 1; endsequence
   property pc(e, c);
      s_ev(e) ##1 s_srd |=> regRdData[2:0] == c;
   endproperty
   a_stuff_lec: assert property (pc(stuffErr, 3'h1))
      else $error("stuff code");
   a_form_lec: assert property (pc(formErr, 3'h2))
      else $error("form code");
   a_ack_lec: assert property (pc(missingAckErr, 3'h3))
      else $error("ack code");
   a_bit1_lec: assert property (pc(recessiveMismatchErr, 3'h4))
      else $error("bit1 code");
   a_bit0_lec: assert property (pc(dominantMismatchErr, 3'h5))
      else $error("bit0 code");
   a_recov_lec: assert property (pc(recoveryElevenRecessive, 3'h5))
      else $error("recovery code");
   a_crc_lec: assert property (pc(checksumMismatchErr, 3'h6))
      else $error("crc code");
   a_rx_clears_lec: assert property (s_ev(rxDone) ##1 s_srd |=>
      regRdData[4] && regRdData[2:0] == 3'h0) else $error("rx ok");
   a_errcnt_view: assert property (s_rd(8'h08) |=>
      regRdData == {$past(receiveErrorCount) >= 8'h80,
      $past(receiveErrorCount[6:0]), $past(transmitErrorCount)})
      else $error("error counters");
   a_intid_view: assert property (s_rd(8'h10) |=>
      regRdData == ($past(statusIrq) ? 16'h8000 : 16'h0000))
      else $error("interrupt id");
   // Only a quiet cycle may clear: a new raise wins over the read
   a_read_clears_irq: assert property (statusIrq && regRdStb &&
      regAddr == 8'h04 && ev == 9'h000 && $stable(busOffState) &&
      $stable(receiveErrorCount) && $stable(transmitErrorCount)
      |=> !statusIrq) else $error("irq not cleared");
endmodule // cesr_monitor
bind cesr_error_status cesr_monitor mon (.*);
`default_nettype wire

// ### dv/cesr_engine_model.sv
// Purpose: Protocol engine stand-in issuing bus events
// Assumes: Bench holds sel for one cycle per event
// Notes:   sel 1..9 = stuff..tx done; zero is a quiet bus
`timescale 1ns/1ps
`default_nettype none
module cesr_engine_model (
   input  wire [3:0] sel,
   output wire [8:0] pulse
);
   // One-hot so no two events ever coincide
   assign pulse = (sel == 4'h0) ? 9'h000 : 9'h100 >> (sel - 4'h1);
endmodule // cesr_engine_model
`default_nettype wire

// ### dv/cesr_error_status_bench.sv
// Purpose: Self-checking bench for the error status block
// Assumes: Register reads answer in the next cycle
// Notes:   Counts come from a shift register seeded with 37
`timescale 1ns/1ps
`default_nettype none
module cesr_error_status_bench;
   logic        sys_clk = 0, rst = 1, regWrStb = 0, regRdStb = 0;
   logic        bus_off_flag = 0, pas = 0, irqAt, pb, pw;
   logic [7:0]  regAddr = 8'h00, receive_error_count = 8'h00, transmit_error_count = 8'h00;
   logic [15:0] regWrData = 16'h0000, rd, lf = 16'h0025;
   logic [3:0]  sel = 4'h0;
   wire  [15:0] regRdData;
   wire         statusIrq;
   wire  [8:0]  p;
   int          fail_count = 0, n_checks = 0;
   int          code [1:9] = '{1, 2, 3, 4, 5, 5, 6, 0, 0};
   always #12.5 sys_clk = ~sys_clk;
   cesr_engine_model eng (.sel(sel), .pulse(p));
   cesr_error_status dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .stuffErr(p[8]), .formErr(p[7]),
      .missingAckErr(p[6]), .recessiveMismatchErr(p[5]),
      .dominantMismatchErr(p[4]), .recoveryElevenRecessive(p[3]),
      .checksumMismatchErr(p[2]), .rxDone(p[1]), .txDone(p[0]),
      .busOffState(bus_off_flag), .errorPassiveState(pas), .receiveErrorCount(receive_error_count),
      .transmitErrorCount(transmit_error_count), .statusIrq(statusIrq));
   function logic [15:0] nx(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(string n, logic [15:0] s, logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task report_and_stop;
      if (fail_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task wr(logic [7:0] a, logic [15:0] d);
      @(posedge sys_clk);
      sel <= 4'h0; regWrStb <= 1'b1; regAddr <= a; regWrData <= d;
      @(posedge sys_clk);
      regWrStb <= 1'b0;
   endtask
   // Any pending event is dropped here, so it lasts exactly one cycle
   task rdr(logic [7:0] a);
      @(posedge sys_clk);
      sel <= 4'h0; regRdStb <= 1'b1; regAddr <= a;
      #1 irqAt = statusIrq;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      #1 rd = regRdData;
   endtask
   initial begin
      #100us;
      fail_count++;
      report_and_stop;
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      rdr(8'h08); chk("errcnt reset", rd, 16'h0000);
      wr(8'h08, 16'hffff); rdr(8'h08); chk("errcnt ro", rd, 16'h0000);
      rdr(8'h1e); chk("unmapped", rd, 16'h0000);
      wr(8'h00, 16'h000c);
      for (int i = 1; i < 10; i++) begin
         lf = nx(lf);
         pb = bus_off_flag;
         pw = receive_error_count >= 8'h60 || transmit_error_count >= 8'h60;
         @(posedge sys_clk);
         receive_error_count <= lf[7:0]; transmit_error_count <= lf[15:8]; bus_off_flag <= lf[3];
         rdr(8'h08); chk("errcnt", rd, {receive_error_count >= 8'h80, receive_error_count[6:0], transmit_error_count});
         chk("err irq", irqAt, bus_off_flag != pb || (receive_error_count >= 8'h60 || transmit_error_count >= 8'h60) != pw);
         wr(8'h04, 16'h0007); rdr(8'h04);
         chk("flags", rd[7:0], {bus_off_flag, receive_error_count >= 8'h60 || transmit_error_count >= 8'h60, pas, 5'h07});
         @(posedge sys_clk); pas <= ~pas;
         @(posedge sys_clk); #1 chk("quiet irq", statusIrq, 1'b0);
         @(posedge sys_clk); sel <= i[3:0];
         rdr(8'h04); chk("raise", irqAt, 1'b1);
         chk("status", rd[4:0], {i == 8, i == 9, code[i][2:0]});
         rdr(8'h10); chk("intid clear", rd, 16'h0000);
      end
      @(posedge sys_clk); sel <= 4'h7;
      rdr(8'h10); chk("intid set", rd, 16'h8000);
      wr(8'h00, 16'h0000); rdr(8'h04);
      @(posedge sys_clk); sel <= 4'h1;
      rdr(8'h10); chk("masked", rd, 16'h0000);
      report_and_stop;
   end
endmodule // cesr_error_status_bench
`default_nettype wire
